// ==== design/prss_params.svh ====
// Constants for the reset-time PLL ratio strap selection block.
// Assumes nothing beyond inclusion by the package and the design modules.
`ifndef PRSS_PARAMS_SVH
`define PRSS_PARAMS_SVH

// Platform strap codes
`define PRSS_PCODE_16   4'h0
`define PRSS_PCODE_2    4'h2
`define PRSS_PCODE_3    4'h3
`define PRSS_PCODE_4    4'h4
`define PRSS_PCODE_5    4'h5
`define PRSS_PCODE_6    4'h6
`define PRSS_PCODE_8    4'h8
`define PRSS_PCODE_9    4'h9
`define PRSS_PCODE_10   4'ha
`define PRSS_PCODE_12   4'hc
`define PRSS_PCODE_20   4'hd

// Platform multipliers (platform : reference)
`define PRSS_PMUL_16    5'h10
`define PRSS_PMUL_2     5'h02
`define PRSS_PMUL_3     5'h03
`define PRSS_PMUL_4     5'h04
`define PRSS_PMUL_5     5'h05
`define PRSS_PMUL_6     5'h06
`define PRSS_PMUL_8     5'h08
`define PRSS_PMUL_9     5'h09
`define PRSS_PMUL_10    5'h0a
`define PRSS_PMUL_12    5'h0c
`define PRSS_PMUL_20    5'h14

// Core strap codes {bus_ctl, addr_latch, gp_line}
`define PRSS_CCODE_4_1  3'h0
`define PRSS_CCODE_9_2  3'h1
`define PRSS_CCODE_RSV  3'h2
`define PRSS_CCODE_3_2  3'h3
`define PRSS_CCODE_2_1  3'h4
`define PRSS_CCODE_5_2  3'h5
`define PRSS_CCODE_3_1  3'h6
`define PRSS_CCODE_7_2  3'h7

// Core ratio in half steps (core:platform times two)
`define PRSS_CHALF_4_1  4'h8
`define PRSS_CHALF_9_2  4'h9
`define PRSS_CHALF_3_2  4'h3
`define PRSS_CHALF_2_1  4'h4
`define PRSS_CHALF_5_2  4'h5
`define PRSS_CHALF_3_1  4'h6
`define PRSS_CHALF_7_2  4'h7

// Equal readings of the synchronised straps counted before the next one captures
`define PRSS_SETTLE_CYC 4'h3

// Edges the synchroniser needs before its output shows the pins
`define PRSS_SYNC_CYC   4'h2

// Strap vector layout: platform field above core field
`define PRSS_STRAP_W    7
`define PRSS_PFIELD_LSB 3

`endif

// ==== design/prss_pkg.sv ====
// Types for the PLL ratio strap selection block.
// Assumes prss_params.svh is on the include path.
`include "prss_params.svh"

package prss_pkg;

    // Capture sequence states, one-hot
    typedef enum logic [2:0] {
        ST_SYNC = 3'b001,
        ST_WAIT = 3'b010,
        ST_HELD = 3'b100
    } prss_state_t;

    typedef struct packed {
        logic        valid;
        logic        reserved;
        logic [4:0]  mult;
    } prss_pdec_t;

    typedef struct packed {
        logic        valid;
        logic        reserved;
        logic [3:0]  half;
    } prss_cdec_t;

endpackage : prss_pkg

// ==== design/prss_sync.sv ====
// Two-flop synchroniser for a group of strap pins.
// Assumes the pins are quasi-static and may change at any time.
`timescale 1ns/10ps

module prss_sync
    import prss_pkg::*;
#(
    parameter int WIDTH = 7
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } prss_sync_st_t;

    prss_sync_st_t st_reg;
    prss_sync_st_t st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.meta = d_in;
        st_next.sync = st_reg.meta;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q_out = st_reg.sync;

endmodule : prss_sync

// ==== design/prss_top.sv ====
// Reset-time ratio strap capture and decode for the platform and core PLLs.
// Assumes straps are held steady by board resistors while reset is applied
// and for a few cycles after its release; MCLK_IN is the reference clock.
`timescale 1ns/10ps

`include "prss_params.svh"

module prss_top
    import prss_pkg::*;
(
    // Reference clock and power-up reset
    input  wire logic       MCLK_IN,
    input  wire logic       SYS_RST_IN,
    // Strap pins, asynchronous to MCLK_IN
    input  wire logic [3:0] PLATFORM_RATIO_STRAPS_IN,
    input  wire logic       BUS_CTL_CORE_STRAP_IN,
    input  wire logic       ADDR_LATCH_CORE_STRAP_IN,
    input  wire logic       GP_LINE_CORE_STRAP_IN,
    // Captured codes and decoded ratios, from flip-flops
    output logic [3:0]      PLAT_CODE_OUT,
    output logic [4:0]      PLAT_MULT_OUT,
    output logic            PLAT_RESERVED_OUT,
    output logic [2:0]      CORE_CODE_OUT,
    output logic [3:0]      CORE_HALF_RATIO_OUT,
    output logic            CORE_RESERVED_OUT,
    // PLL start levels and capture done
    output logic            PLAT_PLL_EN_OUT,
    output logic            CORE_PLL_EN_OUT,
    output logic            RATIO_VALID_OUT
);

    // Platform code table
    // Reserved codes give multiplier zero so no PLL locks to a guessed ratio
    function automatic prss_pdec_t plat_decode(input logic [3:0] code);
        prss_pdec_t d;
        d = '{valid: 1'b1, reserved: 1'b0, mult: 5'h00};
        case (code)
            `PRSS_PCODE_16: d.mult = `PRSS_PMUL_16;
            `PRSS_PCODE_2:  d.mult = `PRSS_PMUL_2;
            `PRSS_PCODE_3:  d.mult = `PRSS_PMUL_3;
            `PRSS_PCODE_4:  d.mult = `PRSS_PMUL_4;
            `PRSS_PCODE_5:  d.mult = `PRSS_PMUL_5;
            `PRSS_PCODE_6:  d.mult = `PRSS_PMUL_6;
            `PRSS_PCODE_8:  d.mult = `PRSS_PMUL_8;
            `PRSS_PCODE_9:  d.mult = `PRSS_PMUL_9;
            `PRSS_PCODE_10: d.mult = `PRSS_PMUL_10;
            `PRSS_PCODE_12: d.mult = `PRSS_PMUL_12;
            `PRSS_PCODE_20: d.mult = `PRSS_PMUL_20;
            // Reserved: flag it and leave the ratio at zero
            default: begin
                d.valid    = 1'b0;
                d.reserved = 1'b1;
            end
        endcase
        return d;
    endfunction : plat_decode

    // Core code table
    // Half steps keep 9:2, 5:2, 3:2 and 7:2 exact as integers
    function automatic prss_cdec_t core_decode(input logic [2:0] code);
        prss_cdec_t d;
        d = '{valid: 1'b1, reserved: 1'b0, half: 4'h0};
        case (code)
            `PRSS_CCODE_4_1: d.half = `PRSS_CHALF_4_1;
            `PRSS_CCODE_9_2: d.half = `PRSS_CHALF_9_2;
            `PRSS_CCODE_3_2: d.half = `PRSS_CHALF_3_2;
            `PRSS_CCODE_2_1: d.half = `PRSS_CHALF_2_1;
            `PRSS_CCODE_5_2: d.half = `PRSS_CHALF_5_2;
            `PRSS_CCODE_3_1: d.half = `PRSS_CHALF_3_1;
            `PRSS_CCODE_7_2: d.half = `PRSS_CHALF_7_2;
            // Reserved: flag it and leave the ratio at zero
            default: begin
                d.valid    = 1'b0;
                d.reserved = 1'b1;
            end
        endcase
        return d;
    endfunction : core_decode

    // Whole state of the capture sequence in one register
    typedef struct packed {
        prss_state_t state;
        logic [3:0]  settle;
        logic [6:0]  last;
        logic [3:0]  pcode;
        logic [2:0]  ccode;
        prss_pdec_t  pdec;
        prss_cdec_t  cdec;
        logic        held;
    } prss_top_st_t;

    // State after reset: nothing captured, all outputs low
    localparam prss_top_st_t ST_RESET = '{
        state:  ST_SYNC,
        settle: '0,
        last:   '0,
        pcode:  '0,
        ccode:  '0,
        pdec:   '0,
        cdec:   '0,
        held:   1'b0
    };

    prss_top_st_t             st_reg;
    prss_top_st_t             st_next;
    // Synchronised straps, platform field above core field
    logic [`PRSS_STRAP_W-1:0] straps_sync;
    logic [3:0]               plat_sync;
    logic [2:0]               core_sync;
    prss_pdec_t               pdec_now;
    prss_cdec_t               cdec_now;

    // Pins are asynchronous to the clock
    prss_sync #(
        .WIDTH (`PRSS_STRAP_W)
    ) prss_sync_inst (
        .clk_in (MCLK_IN),
        .rst_in (SYS_RST_IN),
        .d_in   ({PLATFORM_RATIO_STRAPS_IN, BUS_CTL_CORE_STRAP_IN,
                  ADDR_LATCH_CORE_STRAP_IN, GP_LINE_CORE_STRAP_IN}),
        .q_out  (straps_sync)
    );

    assign plat_sync = straps_sync[`PRSS_STRAP_W-1:`PRSS_PFIELD_LSB];
    assign core_sync = straps_sync[`PRSS_PFIELD_LSB-1:0];

    always_comb begin
        // Next state: copy, then change only what this cycle moves
        st_next  = st_reg;
        pdec_now = plat_decode(plat_sync);
        cdec_now = core_decode(core_sync);

        case (st_reg.state)
            ST_SYNC: begin
                // Two edges fill the synchroniser first;
                // its reset zeros are not strap levels
                if (st_reg.settle == `PRSS_SYNC_CYC) begin
                    st_next.last   = straps_sync;
                    st_next.settle = 4'h0;
                    st_next.state  = ST_WAIT;
                end else begin
                    st_next.settle = st_reg.settle + 4'h1;
                end
            end
            ST_WAIT: begin
                // Filters strap glitches around reset release
                st_next.last = straps_sync;
                if (straps_sync != st_reg.last) begin
                    st_next.settle = 4'h0;
                // Straps must read equal one edge more than this count in a row
                end else if (st_reg.settle == `PRSS_SETTLE_CYC) begin
                    // Capture once per reset
                    // Codes and decodes move together so no port shows a mix
                    st_next.pcode = plat_sync;
                    st_next.ccode = core_sync;
                    st_next.pdec  = pdec_now;
                    st_next.cdec  = cdec_now;
                    st_next.held  = 1'b1;
                    st_next.state = ST_HELD;
                end else begin
                    st_next.settle = st_reg.settle + 4'h1;
                end
            end
            ST_HELD: begin
                // Strap changes ignored
                // Only reset leaves; a late glitch cannot restart the PLLs
                st_next.state = ST_HELD;
            end
            default: begin
                // Broken one-hot code restarts capture
                st_next.state = ST_SYNC;
            end
        endcase
    end

    // Async reset drops the PLL enables before the clock can be trusted
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign PLAT_CODE_OUT       = st_reg.pcode;
    assign PLAT_MULT_OUT       = st_reg.pdec.mult;
    assign PLAT_RESERVED_OUT   = st_reg.held & st_reg.pdec.reserved;

    assign CORE_CODE_OUT       = st_reg.ccode;
    assign CORE_HALF_RATIO_OUT = st_reg.cdec.half;
    assign CORE_RESERVED_OUT   = st_reg.held & st_reg.cdec.reserved;

    // Only the platform and core ratios are settled here; the PCI
    // local bus and serial-link PLLs take their settings elsewhere
    // Platform PLL runs on valid code
    assign PLAT_PLL_EN_OUT     = st_reg.held & st_reg.pdec.valid;
    assign CORE_PLL_EN_OUT     = st_reg.held & st_reg.pdec.valid
                                 & st_reg.cdec.valid;
    assign RATIO_VALID_OUT     = st_reg.held;

endmodule : prss_top

// ==== sim/prss_top_asserts.sv ====
// Checker on the ports of the ratio strap block.
// Assumes straps stay still from reset until capture.
`timescale 1ns/10ps
module prss_top_asserts (
    input wire logic       MCLK_IN,
    input wire logic       SYS_RST_IN,
    input wire logic [3:0] PLATFORM_RATIO_STRAPS_IN,
    input wire logic       BUS_CTL_CORE_STRAP_IN,
    input wire logic       ADDR_LATCH_CORE_STRAP_IN,
    input wire logic       GP_LINE_CORE_STRAP_IN,
    input wire logic [3:0] PLAT_CODE_OUT,
    input wire logic [4:0] PLAT_MULT_OUT,
    input wire logic       PLAT_RESERVED_OUT,
    input wire logic [2:0] CORE_CODE_OUT,
    input wire logic [3:0] CORE_HALF_RATIO_OUT,
    input wire logic       CORE_RESERVED_OUT,
    input wire logic       PLAT_PLL_EN_OUT,
    input wire logic       CORE_PLL_EN_OUT,
    input wire logic       RATIO_VALID_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    logic [3:0] since_reg;
    // Saturates so a long run never wraps back to early values
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) since_reg <= 4'h0;
        else if (since_reg != 4'hf) since_reg <= since_reg + 4'h1;
    end
    sequence cap_s;
        $rose(RATIO_VALID_OUT);
    endsequence
    valid_early_a: assert property (since_reg < 4'h7 |-> !RATIO_VALID_OUT)
        else $error("ratio valid before settle time");
    valid_late_a: assert property (since_reg == 4'h9 |-> RATIO_VALID_OUT)
        else $error("ratio valid missing after steady straps");
    capture_val_a: assert property (cap_s |->
        PLAT_CODE_OUT == $past(PLATFORM_RATIO_STRAPS_IN, 4)
        && CORE_CODE_OUT == {$past(BUS_CTL_CORE_STRAP_IN, 4),
        $past(ADDR_LATCH_CORE_STRAP_IN, 4), $past(GP_LINE_CORE_STRAP_IN, 4)})
        else $error("captured code differs from straps");
    held_codes_a: assert property (RATIO_VALID_OUT |=>
        RATIO_VALID_OUT && $stable(PLAT_CODE_OUT) && $stable(CORE_CODE_OUT)
        && $stable(PLAT_MULT_OUT) && $stable(CORE_HALF_RATIO_OUT))
        else $error("captured ratio moved");
    plat_rsv_a: assert property (RATIO_VALID_OUT |->
        PLAT_RESERVED_OUT == (PLAT_CODE_OUT inside {4'h1, 4'h7, 4'hb, 4'he, 4'hf}))
        else $error("platform reserved flag wrong");
    plat_zero_a: assert property (PLAT_RESERVED_OUT |-> PLAT_MULT_OUT == 5'h00)
        else $error("reserved platform code gives ratio");
    core_rsv_a: assert property (RATIO_VALID_OUT |->
        (CORE_RESERVED_OUT == (CORE_CODE_OUT == 3'h2))
        && (CORE_RESERVED_OUT == (CORE_HALF_RATIO_OUT == 4'h0)))
        else $error("core reserved flag wrong");
    plat_en_a: assert property (PLAT_PLL_EN_OUT == (RATIO_VALID_OUT && !PLAT_RESERVED_OUT))
        else $error("platform pll enable wrong");
    core_en_a: assert property (CORE_PLL_EN_OUT ==
        (PLAT_PLL_EN_OUT && !CORE_RESERVED_OUT))
        else $error("core pll enable wrong");
endmodule : prss_top_asserts

bind prss_top prss_top_asserts prss_top_asserts_inst (.MCLK_IN(MCLK_IN),
    .SYS_RST_IN(SYS_RST_IN), .PLATFORM_RATIO_STRAPS_IN(PLATFORM_RATIO_STRAPS_IN),
    .BUS_CTL_CORE_STRAP_IN(BUS_CTL_CORE_STRAP_IN),
    .ADDR_LATCH_CORE_STRAP_IN(ADDR_LATCH_CORE_STRAP_IN),
    .GP_LINE_CORE_STRAP_IN(GP_LINE_CORE_STRAP_IN), .PLAT_CODE_OUT(PLAT_CODE_OUT),
    .PLAT_MULT_OUT(PLAT_MULT_OUT), .PLAT_RESERVED_OUT(PLAT_RESERVED_OUT),
    .CORE_CODE_OUT(CORE_CODE_OUT), .CORE_HALF_RATIO_OUT(CORE_HALF_RATIO_OUT),
    .CORE_RESERVED_OUT(CORE_RESERVED_OUT), .PLAT_PLL_EN_OUT(PLAT_PLL_EN_OUT),
    .CORE_PLL_EN_OUT(CORE_PLL_EN_OUT), .RATIO_VALID_OUT(RATIO_VALID_OUT));

// ==== sim/prss_board_model.sv ====
// Board strap resistors as a model.
// Assumes the bench picks the code; every line is always pulled.
`timescale 1ns/10ps
module prss_board_model (
    input  wire logic [3:0] plat_code_in,
    input  wire logic [2:0] core_code_in,
    output logic      [3:0] plat_straps_out,
    output logic            bus_ctl_out,
    output logic            addr_latch_out,
    output logic            gp_line_out
);
    assign plat_straps_out = plat_code_in;
    assign {bus_ctl_out, addr_latch_out, gp_line_out} = core_code_in;
    // Clock plan is the board's: reference at or below 100 MHz and
    // a ratio matching the DDR rate; the bench clock only paces capture
endmodule : prss_board_model

// ==== sim/prss_top_tb.sv ====
// Bench for the ratio strap block.
// Assumes the board model drives the straps at all times.
`timescale 1ns/10ps
module prss_top_tb;
    import prss_pkg::*;
    logic       mclk = 1'b0;
    logic       rst  = 1'b1;
    logic [3:0] pcode = 4'h0;
    logic [2:0] ccode = 3'h0;
    logic [3:0] straps, p_code, c_half;
    logic [2:0] c_code;
    logic [4:0] p_mult;
    logic       bc, al, gp, p_rsv, c_rsv, p_en, c_en, valid;
    int         failures = 0;
    int         compares = 0;
    initial forever #4 mclk = ~mclk;
    prss_board_model prss_board_model_inst (.plat_code_in(pcode), .core_code_in(ccode),
        .plat_straps_out(straps), .bus_ctl_out(bc), .addr_latch_out(al), .gp_line_out(gp));
    prss_top prss_top_inst (.MCLK_IN(mclk), .SYS_RST_IN(rst), .PLATFORM_RATIO_STRAPS_IN(straps),
        .BUS_CTL_CORE_STRAP_IN(bc), .ADDR_LATCH_CORE_STRAP_IN(al), .GP_LINE_CORE_STRAP_IN(gp),
        .PLAT_CODE_OUT(p_code), .PLAT_MULT_OUT(p_mult), .PLAT_RESERVED_OUT(p_rsv),
        .CORE_CODE_OUT(c_code), .CORE_HALF_RATIO_OUT(c_half), .CORE_RESERVED_OUT(c_rsv),
        .PLAT_PLL_EN_OUT(p_en), .CORE_PLL_EN_OUT(c_en), .RATIO_VALID_OUT(valid));
    function automatic logic [4:0] exp_mult(input logic [3:0] c);
        case (c)
            4'h0: exp_mult = 5'h10;
            4'hd: exp_mult = 5'h14;
            4'h1, 4'h7, 4'hb, 4'he, 4'hf: exp_mult = 5'h00;
            default: exp_mult = {1'b0, c};
        endcase
    endfunction : exp_mult
    function automatic logic [3:0] exp_half(input logic [2:0] c);
        case (c)
            3'h0: exp_half = 4'h8;
            3'h1: exp_half = 4'h9;
            3'h2: exp_half = 4'h0;
            default: exp_half = {1'b0, c};
        endcase
    endfunction : exp_half
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic do_reset();
        rst = 1'b1;
        repeat (16) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (6) @(posedge mclk);
        #1 chk(valid, 1'b0);
        for (int n = 0; n < 4 && valid !== 1'b1; n++) @(posedge mclk) #1;
        chk(valid, 1'b1);
    endtask : do_reset
    task automatic t_decode();
        logic rp;
        for (int i = 0; i < 16; i++) begin
            pcode = i[3:0];
            ccode = i[2:0];
            rp = (exp_mult(pcode) == 5'h00);
            do_reset();
            chk(p_code, pcode);
            chk(c_code, ccode);
            chk(p_mult, exp_mult(pcode));
            chk(p_rsv, rp);
            chk(c_half, exp_half(ccode));
            chk(c_rsv, ccode == 3'h2);
            chk(p_en, !rp);
            chk(c_en, !rp && ccode != 3'h2);
        end
        $display("test decode done");
    endtask : t_decode
    task automatic t_hold();
        pcode = 4'hd;
        ccode = 3'h5;
        do_reset();
        pcode = 4'h1;
        ccode = 3'h2;
        repeat (12) @(posedge mclk);
        #1 chk(p_code, 4'hd);
        chk(p_mult, 5'h14);
        chk(c_half, 4'h5);
        chk(c_en, 1'b1);
        $display("test hold done");
    endtask : t_hold
    task automatic test_done();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    initial begin
        t_decode();
        t_hold();
        test_done();
    end
    // Whole run needs about 3.2 us
    initial begin
        #40000;
        failures++;
        test_done();
    end
endmodule : prss_top_tb
